// *** hw/hbs_bridge_ctrl.sv ***
// phase sequencing, chop pacing and dead time for one h bridge
// assumes synchronous inputs; osc tick is one mclk pulse per oscillator period
`include "hbs_consts.svh"
`default_nettype none
module hbs_bridge_ctrl #(
   parameter int DEAD_CYC = `HBS_DEAD_CYC,
   parameter int CHOP_PER = `HBS_CHOP_OSC_PER
) (
   input wire logic mclk_in, // 100 MHz clock
   input wire logic rst_in, // sync reset, active high
   input wire logic standby_n_pin_in, // low selects standby
   input wire logic chop_oscillator_in, // one-cycle tick per oscillator period
   input wire logic dir_reverse_in, // current direction
   input wire logic current_reached_in, // winding current at target
   input wire logic decay_ratio_sel_lo_in, // decay ratio select low bit
   input wire logic decay_ratio_sel_hi_in, // decay ratio select high bit
   input wire logic angle_step_in, // advance electrical angle
   input wire logic [2:0] step_mode_in, // step resolution to load
   input wire logic step_mode_load_in, // load step resolution
   output logic high_side_left_out, // left high switch on
   output logic high_side_right_out, // right high switch on
   output logic low_side_left_out, // left low switch on
   output logic low_side_right_out, // right low switch on
   output logic [1:0] phase_out, // current phase
   output logic [7:0] angle_out, // electrical angle index
   output logic [2:0] step_mode_out // step resolution
);
   logic logic_rst;
   hbs_pkg::hbs_phase_e phase_r, phase_nxt;
   logic [4:0] chop_cnt_r, chop_cnt_nxt;
   logic [4:0] fast_len;
   logic [7:0] angle_r, angle_nxt;
   logic [2:0] step_r, step_nxt;
   logic [3:0] want, sw_r;

   assign logic_rst = rst_in | ~standby_n_pin_in;

   always_comb
   begin
      unique case ({decay_ratio_sel_hi_in, decay_ratio_sel_lo_in})
         2'h0: fast_len = 5'(`HBS_FAST_OSC_DEF);
         2'h1: fast_len = 5'(`HBS_FAST_OSC_75);
         2'h2: fast_len = 5'(`HBS_FAST_OSC_50);
         default: fast_len = 5'(`HBS_FAST_OSC_ONLY);
      endcase
   end

   // chop cycle: charge until target, slow unless the fast tail covers the rest, then fast for the tail
   always_comb
   begin
      phase_nxt = phase_r;
      chop_cnt_nxt = chop_cnt_r;
      if (chop_oscillator_in)
      begin
         chop_cnt_nxt = (chop_cnt_r == 5'(CHOP_PER - 1)) ? 5'h00 : chop_cnt_r + 5'h01;
         unique case (phase_r)
            hbs_pkg::HBS_CHARGE:
            begin
               if (current_reached_in)
                  phase_nxt = (fast_len >= 5'(CHOP_PER) - chop_cnt_r) ?
                     hbs_pkg::HBS_FAST : hbs_pkg::HBS_SLOW;
               else if (chop_cnt_r == 5'(CHOP_PER - 1))
                  chop_cnt_nxt = chop_cnt_r; // charge extends past one cycle
            end
            hbs_pkg::HBS_SLOW:
               if (chop_cnt_r + 5'h01 + fast_len >= 5'(CHOP_PER))
                  phase_nxt = hbs_pkg::HBS_FAST;
            hbs_pkg::HBS_FAST:
               if (chop_cnt_r == 5'(CHOP_PER - 1))
                  phase_nxt = hbs_pkg::HBS_CHARGE;
         endcase
      end
   end

   // target switches {hl, hr, ll, lr}
   always_comb
   begin
      unique case (phase_r)
         hbs_pkg::HBS_CHARGE: want = dir_reverse_in ? 4'h6 : 4'h9;
         hbs_pkg::HBS_SLOW: want = 4'h3;
         default: want = dir_reverse_in ? 4'h9 : 4'h6;
      endcase
   end

   // one leg per pass: 0 = left (hl, ll), 1 = right (hr, lr)
   for (genvar leg = 0; leg < 2; leg++)
   begin : g_leg
      logic want_hi;
      logic want_lo;
      logic hi_r, hi_nxt;
      logic lo_r, lo_nxt;
      logic [7:0] dead_cnt_r, dead_cnt_nxt;

      assign want_hi = want[3 - leg];
      assign want_lo = want[1 - leg];

      // off first, wait out the dead count, then apply the target
      always_comb
      begin
         hi_nxt = hi_r;
         lo_nxt = lo_r;
         dead_cnt_nxt = dead_cnt_r;
         if (dead_cnt_r != 8'h00)
            dead_cnt_nxt = dead_cnt_r - 8'h01;
         else if ({want_hi, want_lo} != {hi_r, lo_r})
         begin
            if (hi_r | lo_r)
            begin
               hi_nxt = 1'b0;
               lo_nxt = 1'b0;
               dead_cnt_nxt = 8'(DEAD_CYC - 1);
            end
            else
            begin
               hi_nxt = want_hi;
               lo_nxt = want_lo;
            end
         end
      end

      always_ff @(posedge mclk_in)
      begin
         if (logic_rst)
         begin
            hi_r <= 1'b0;
            lo_r <= 1'b0;
            dead_cnt_r <= 8'h00;
         end
         else
         begin
            hi_r <= hi_nxt;
            lo_r <= lo_nxt;
            dead_cnt_r <= dead_cnt_nxt;
         end
      end

      assign sw_r[3 - leg] = hi_r;
      assign sw_r[1 - leg] = lo_r;
   end

   always_comb
   begin
      angle_nxt = angle_step_in ? angle_r + 8'h01 : angle_r;
      step_nxt = step_mode_load_in ? step_mode_in : step_r;
   end

   // chop sequencer state
   always_ff @(posedge mclk_in)
   begin
      if (logic_rst)
      begin
         phase_r <= hbs_pkg::HBS_CHARGE;
         chop_cnt_r <= 5'h00;
      end
      else
      begin
         phase_r <= phase_nxt;
         chop_cnt_r <= chop_cnt_nxt;
      end
   end

   // angle and step resolution state
   always_ff @(posedge mclk_in)
   begin
      if (logic_rst)
      begin
         angle_r <= `HBS_ANGLE_INIT;
         step_r <= `HBS_STEP_INIT;
      end
      else
      begin
         angle_r <= angle_nxt;
         step_r <= step_nxt;
      end
   end

   assign high_side_left_out = sw_r[3];
   assign high_side_right_out = sw_r[2];
   assign low_side_left_out = sw_r[1];
   assign low_side_right_out = sw_r[0];
   assign phase_out = phase_r;
   assign angle_out = angle_r;
   assign step_mode_out = step_r;
endmodule : hbs_bridge_ctrl
`default_nettype wire

// *** hw/hbs_consts.svh ***
// What this block does
// - standby pin low enters standby, high returns to normal operation
// - standby holds logic in reset, angle back to 45 deg, step mode initial
// - forward: charge HL+LR, slow both lows, fast HR+LL
// - reverse: charge HR+LL, slow both lows, fast HL+LR
// - phases change automatically to keep winding current constant
// - dead interval inserted on every complementary leg change
// - chop period derived from resistor-set oscillator, 1266 kHz gives 79 kHz
// - each chop cycle runs charge, then slow decay unless the fast tail covers the rest (always with select 3), then fast decay
// - default fast decay is six oscillator periods, 37.5 percent ratio
//
// constants for the h-bridge phase switch controller
// assumes a 100 MHz mclk_in
`ifndef HBS_CONSTS_SVH
`define HBS_CONSTS_SVH
`define HBS_CLK_MHZ 100
`define HBS_DEAD_NS 200
`define HBS_DEAD_CYC ((`HBS_DEAD_NS * `HBS_CLK_MHZ + 999) / 1000)
`define HBS_CHOP_OSC_PER 16
`define HBS_FAST_OSC_DEF 6
`define HBS_FAST_OSC_75 12
`define HBS_FAST_OSC_50 8
`define HBS_FAST_OSC_ONLY 16
`define HBS_ANGLE_INIT 8'h20
`define HBS_STEP_INIT 3'h0
`endif

// *** hw/hbs_pkg.sv ***
// types for the h-bridge phase switch controller
// assumes nothing beyond hbs_consts.svh
`default_nettype none
package hbs_pkg;
   typedef enum logic [1:0] {HBS_CHARGE, HBS_SLOW, HBS_FAST} hbs_phase_e;
endpackage : hbs_pkg
`default_nettype wire

// *** tb/hbs_bridge_ctrl_props.sv ***
// checker on the bridge controller ports
// bound into every hbs_bridge_ctrl instance
`default_nettype none
module hbs_bridge_ctrl_props (
   input wire logic mclk_in, rst_in, standby_n_pin_in, chop_oscillator_in,
   input wire logic current_reached_in, high_side_left_out, high_side_right_out,
   input wire logic low_side_left_out, low_side_right_out,
   input wire logic [1:0] phase_out,
   input wire logic [7:0] angle_out,
   input wire logic [2:0] step_mode_out
);
   wire hl = high_side_left_out, hr = high_side_right_out;
   wire ll = low_side_left_out, lr = low_side_right_out;
   wire [1:0] p = phase_out;
   wire cr = current_reached_in;
   default clocking @(posedge mclk_in); endclocking
   default disable iff (rst_in);
   sequence s_slow2; p == 2'h1 ##1 p == 2'h1; endsequence
   property p_shoot; !(hl && ll) && !(hr && lr); endproperty
   a_shoot: assert property (p_shoot) else $error("leg shoot");
   property p_dead_l; $rose(ll) || $rose(hl) |-> $past(!hl && !ll); endproperty
   a_dead_l: assert property (p_dead_l) else $error("left dead");
   property p_dead_r; $rose(lr) || $rose(hr) |-> $past(!hr && !lr); endproperty
   a_dead_r: assert property (p_dead_r) else $error("right dead");
   property p_standby_n_pin; !standby_n_pin_in |=> angle_out == 8'h20 && step_mode_out == 3'h0
      && p == 2'h0 && !(hl || hr || ll || lr); endproperty
   a_standby_n_pin: assert property (p_standby_n_pin) else $error("standby");
   property p_slow; s_slow2 |-> !hl && !hr; endproperty
   a_slow: assert property (p_slow) else $error("slow");
   property p_order; p == 2'h1 && $past(p) != 2'h1 |-> $past(p) == 2'h0; endproperty
   a_order: assert property (p_order) else $error("order");
   property p_tick; p != $past(p) |-> $past(chop_oscillator_in)
      || $past(chop_oscillator_in, 2) || !$past(standby_n_pin_in) || $past(rst_in); endproperty
   a_tick: assert property (p_tick) else $error("tick");
   property p_chg; p != 2'h0 && $past(p) == 2'h0 |-> $past(cr) || $past(cr, 2); endproperty
   a_chg: assert property (p_chg) else $error("charge end");
endmodule : hbs_bridge_ctrl_props
bind hbs_bridge_ctrl hbs_bridge_ctrl_props hbs_bridge_ctrl_props_i (.*);
`default_nettype wire

// *** tb/hbs_winding_model.sv ***
// winding model: current ramps while driven, decays otherwise
// assumes drive_in high while the charge pair conducts
`default_nettype none
module hbs_winding_model (
   input wire logic clk_in, // clock
   input wire logic rst_in, // sync reset
   input wire logic drive_in, // winding driven
   input wire logic [7:0] target_in, // target level
   output logic reached_out // level at target
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] lvl_r;
   always_ff @(posedge clk_in)
      lvl_r <= rst_in ? 8'h00 : drive_in ? lvl_r + 8'h01 : lvl_r - {7'h00, |lvl_r};
   assign reached_out = lvl_r >= target_in;
endmodule : hbs_winding_model
`default_nettype wire

// *** tb/tb.sv ***
// self-checking bench for hbs_bridge_ctrl with winding model
// assumes the bound checker and model are compiled first
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin fail_count++; \
   $display("[ERR] %0t %h %h", $time, a, b); end end
   logic mclk_in = 0, rst_in = 1, standby_n_pin = 1, tick = 0, dir = 0, sl = 0, sh = 0;
   logic ast = 0, ld = 0, chk = 0, cr, hl, hr, ll, lr;
   logic [1:0] ph, lp;
   logic [2:0] sm = 0, smo;
   logic [7:0] tgt = 8'h02, ang, exp_ang;
   logic [2:0] exp_sm;
   int fail_count = 0, n_compared = 0, run = 0, stab = 0, tc = 0;
   always #5 mclk_in = ~mclk_in;
   hbs_bridge_ctrl #(.DEAD_CYC(3)) hbs_bridge_ctrl_i (.mclk_in(mclk_in), .rst_in(rst_in),
      .standby_n_pin_in(standby_n_pin), .chop_oscillator_in(tick), .dir_reverse_in(dir),
      .current_reached_in(cr), .decay_ratio_sel_lo_in(sl), .decay_ratio_sel_hi_in(sh),
      .angle_step_in(ast), .step_mode_in(sm), .step_mode_load_in(ld),
      .high_side_left_out(hl), .high_side_right_out(hr), .low_side_left_out(ll),
      .low_side_right_out(lr), .phase_out(ph), .angle_out(ang), .step_mode_out(smo));
   hbs_winding_model hbs_winding_model_i (.clk_in(mclk_in), .rst_in(rst_in),
      .drive_in(dir ? hr && ll : hl && lr), .target_in(tgt), .reached_out(cr));
   function automatic int flen(logic [1:0] s);
      return s == 2'h0 ? 6 : s == 2'h1 ? 12 : s == 2'h2 ? 8 : 16;
   endfunction : flen
   // switch set {hl, hr, ll, lr} for a settled phase
   function automatic logic [3:0] exp_sw(logic [1:0] p, logic d);
      return p == 2'h1 ? 4'h3 : ((p == 2'h0) ^ d) ? 4'h9 : 4'h6;
   endfunction : exp_sw
   always @(posedge mclk_in)
   begin
      tc <= (tc + 1) % 4;
      tick <= tc == 3;
      exp_ang <= (rst_in || !standby_n_pin) ? 8'h20 : exp_ang + 8'(ast);
      exp_sm <= (rst_in || !standby_n_pin) ? 3'h0 : ld ? sm : exp_sm;
      {ast, ld, sm} <= 5'($urandom);
   end
   always @(negedge mclk_in)
   begin
      stab = ph === lp ? stab + 1 : 0;
      if (!rst_in) `CHK({ang, smo}, {exp_ang, exp_sm})
      if (chk && stab == 6) `CHK({hl, hr, ll, lr}, exp_sw(ph, dir))
      if (chk && lp == 2'h2 && ph == 2'h0 && {sh, sl} != 2'h3)
         `CHK(run, 4 * flen({sh, sl}))
      if (chk && {sh, sl} == 2'h3) `CHK(ph == 2'h1, 1'b0)
      run = ph == 2'h2 ? run + 1 : 0;
      lp = ph;
   end
   task wrap_up;
      $display("mismatches %0d, compared %0d", fail_count, n_compared);
      if (fail_count == 0 && n_compared > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : wrap_up
   initial
   begin
      #60000;
      fail_count++;
      wrap_up();
   end
   initial
   begin
      void'($urandom(32'h37747fee));
      repeat (2) @(posedge mclk_in);
      rst_in <= 1'b0;
      @(negedge mclk_in) `CHK({ang, smo}, {8'h20, 3'h0})
      for (int i = 0; i < 8; i++)
      begin
         @(posedge mclk_in);
         {sh, sl, dir} <= 3'(i);
         tgt <= 8'($urandom_range(4, 1));
         chk <= 1'b0;
         repeat (130) @(posedge mclk_in);
         chk <= 1'b1;
         repeat (200) @(posedge mclk_in);
      end
      // long charge spans chop cycles
      chk <= 1'b0;
      tgt <= 8'hC8;
      repeat (190) @(posedge mclk_in);
      @(negedge mclk_in) `CHK(ph, 2'h0)
      @(posedge mclk_in);
      standby_n_pin <= 1'b0;
      @(posedge mclk_in) standby_n_pin <= 1'b1;
      @(negedge mclk_in) `CHK({ang, smo, hl, hr, ll, lr}, {8'h20, 3'h0, 4'h0})
      wrap_up();
   end
endmodule : tb
`default_nettype wire
